// ### xdmi_pkg.sv
// Shared constants, types and state layout of the external data memory interface.
// What this block does
// R01 - Eight-bit form takes address high byte from the page select register.
// R02 - Sixteen-bit form uses the whole data pointer as the address.
// R03 - Data pointer is visible as a high byte and a low byte register.
// R04 - Eight-bit form takes address low byte from index register zero or one.
// R05 - Accesses go to data RAM space, except writes while flash writing is enabled.
// R06 - Eight kilobytes of on-chip RAM sit in the external data space.
// R07 - Port pins are claimed only while an off-chip access runs.
// R08 - After an off-chip access the pins go back to port latches.
// R09 - Drivers of pins acting as inputs are off during an access.
// R10 - Push-pull or open-drain choice stays with the output mode registers.
// R11 - The memory port and segment display never run together.
// R12 - Muxed mode: strobes and latch enable on port 3, address/data on ports 6, 5.
// R13 - Non-muxed mode: data on port 6, low address port 5, high address port 4.
// R14 - Eight-bit form in split mode without bank select uses no upper address pins.
// R15 - Software uses ports 3 to 6 only for this port or plain I/O.
// R16 - Software sets modes, latches, mux mode, memory mode, then timing.
// R17 - Four memory modes: on-chip, split, split with bank, off-chip only.
// R18 - Software parks the port latches high between accesses.
// R19 - Each page select value picks one 256-byte page.
// R20 - Mux select bit: zero shares address/data pins, one separates them.
// R21 - Muxed mode puts low address out and pulses latch enable first.
// R22 - Off-chip reads pulse the read strobe, writes the write strobe.
package xdmi_pkg;

  // ==========================================================================
  // Register map
  localparam logic [2:0] REG_PAGE   = 3'h0;
  localparam logic [2:0] REG_CFG    = 3'h1;
  localparam logic [2:0] REG_PTRH   = 3'h2;
  localparam logic [2:0] REG_PTRL   = 3'h3;
  localparam logic [2:0] REG_STAT   = 3'h4;
  localparam logic [2:0] REG_CTRL   = 3'h5;
  localparam int         CFG_MUX    = 4;
  localparam int         CFG_MODE_L = 2;
  localparam int         CTRL_FLASH = 0;
  localparam int         STAT_BUSY  = 0;
  localparam int         STAT_OWN   = 1;
  localparam int         STAT_CONF  = 2;
  localparam int         STAT_OFF   = 3;

  // ==========================================================================
  // Memory modes and on-chip RAM size
  localparam logic [1:0] MM_ONCHIP     = 2'h0;
  localparam logic [1:0] MM_SPLIT      = 2'h1;
  localparam logic [1:0] MM_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MM_OFFCHIP    = 2'h3;
  localparam int         RAM_AW        = 13;

  // ==========================================================================
  // Bus timing, printed in ns and rounded up to whole 5 ns cycles
  localparam int         CLK_PS    = 5000;
  localparam int         T_ALE_NS  = 10;
  localparam int         T_ADDR_NS = 5;
  localparam int         T_STRB_NS = 40;
  localparam int         T_HOLD_NS = 5;
  localparam logic [3:0] ALE_CYC   = 4'((T_ALE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] ADDR_CYC  = 4'((T_ADDR_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] STRB_CYC  = 4'((T_STRB_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] HOLD_CYC  = 4'((T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // ==========================================================================
  // Types
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_RAM = 7'h02, ST_RAMD = 7'h04, ST_ALE = 7'h08,
    ST_ADDR = 7'h10, ST_STRB = 7'h20, ST_HOLD = 7'h40
  } xdmi_fsm_type;

  typedef struct packed {
    logic [7:0] p6;
    logic [7:0] p5;
    logic [7:0] p4;
    logic [7:0] p3;
  } xdmi_port_type;

  typedef struct packed {
    logic       valid;
    logic       wr;
    logic       form16;
    logic       idx_sel;
    logic [7:0] idx0;
    logic [7:0] idx1;
    logic [7:0] wdata;
  } xdmi_req_type;

  typedef struct packed {
    logic       done;
    logic       busy;
    logic [7:0] rdata;
  } xdmi_rsp_type;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } xdmi_flash_type;

  typedef struct packed {
    xdmi_fsm_type st;
    logic [7:0]   page;
    logic [7:0]   ptr_hi;
    logic [7:0]   ptr_lo;
    logic         nonmux;
    logic [1:0]   mem_mode;
    logic         flash_en;
    logic         conflict;
    logic         last_off;
    logic [7:0]   reg_rdata;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    logic         is_wr;
    logic         hi_pins;
    logic [3:0]   cnt;
    logic [7:0]   rdata;
    logic         done;
    logic         flash_wr;
    logic [7:0]   sync1;
    logic [7:0]   sync2;
    logic [7:0]   sync3;
    logic [7:0]   filt;
  } xdmi_state_type;

  localparam xdmi_state_type STATE_RST = '{st: ST_IDLE, default: '0};

endpackage

// ### xdmi_ram.sv
// On-chip data RAM mapped into the external data space.
`timescale 1ns/1ps
`default_nettype none
module xdmi_ram #(
  parameter int AW = 13
) (
  input  wire logic          clk_in,
  input  wire logic          en_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    wdata_in,
  output logic      [7:0]    rdata_out
);
  logic [7:0] mem [0:(1 << AW) - 1];

  // No reset on purpose: RAM content is undefined after power-up anyway.
  always_ff @(posedge clk_in) begin
    if (en_in) begin
      if (we_in) begin
        mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
    end
  end
endmodule
`default_nettype wire

// ### xdmi_pins.sv
// Per-pin merge of memory port drive with the port latches and output modes.
`timescale 1ns/1ps
`default_nettype none
module xdmi_pins (
  input  wire xdmi_pkg::xdmi_port_type own_in,
  input  wire xdmi_pkg::xdmi_port_type val_in,
  input  wire xdmi_pkg::xdmi_port_type drv_in,
  input  wire xdmi_pkg::xdmi_port_type latch_in,
  input  wire xdmi_pkg::xdmi_port_type od_in,
  output xdmi_pkg::xdmi_port_type      pin_out,
  output xdmi_pkg::xdmi_port_type      oe_n_out
);
  import xdmi_pkg::*;
  logic [31:0] own_w;
  logic [31:0] val_w;
  logic [31:0] drv_w;
  logic [31:0] lat_w;
  logic [31:0] od_w;
  logic [31:0] out_w;
  logic [31:0] oen_w;

  assign own_w = own_in;
  assign val_w = val_in;
  assign drv_w = drv_in;
  assign lat_w = latch_in;
  assign od_w  = od_in;

  // An open-drain pin releases rather than drives a one; the mode is never touched here.
  for (genvar i = 0; i < 32; i++) begin : g_pin
    assign out_w[i] = own_w[i] ? val_w[i] : lat_w[i]; // R08
    assign oen_w[i] = own_w[i] ? (~drv_w[i] | (od_w[i] & val_w[i])) : (od_w[i] & lat_w[i]); // R09 R10
  end

  assign pin_out  = out_w;
  assign oe_n_out = oen_w;
endmodule
`default_nettype wire

// ### xdmi_top.sv
// External data memory interface: on-chip RAM, off-chip parallel bus and registers.
`timescale 1ns/1ps
`default_nettype none
module xdmi_top #(
  parameter int RAM_AW = xdmi_pkg::RAM_AW
) (
  input  wire logic                     REF_CLK_IN,
  input  wire logic                     RST_IN,
  input  wire logic [2:0]               REG_ADDR_IN,
  input  wire logic [7:0]               REG_WDATA_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic                     REG_RD_IN,
  output logic      [7:0]               REG_RDATA_OUT,
  input  wire xdmi_pkg::xdmi_req_type   MOVX_REQ_IN,
  output xdmi_pkg::xdmi_rsp_type        MOVX_RSP_OUT,
  output xdmi_pkg::xdmi_flash_type      FLASH_OUT,
  input  wire logic                     LCD_ACTIVE_IN,
  output logic                          EXT_ACTIVE_OUT,
  input  wire xdmi_pkg::xdmi_port_type  PIN_IN,
  input  wire xdmi_pkg::xdmi_port_type  LATCH_IN,
  input  wire xdmi_pkg::xdmi_port_type  OPEN_DRAIN_IN,
  output xdmi_pkg::xdmi_port_type       PIN_OUT,
  output xdmi_pkg::xdmi_port_type       PIN_OE_N_OUT
);
  import xdmi_pkg::*;

  // ==========================================================================
  // Routing helper
  function automatic logic goes_offchip(input logic [15:0] a, input logic [1:0] m);
    goes_offchip = (m == MM_OFFCHIP) || ((m != MM_ONCHIP) && (a[15:RAM_AW] != '0)); // R06 R17
  endfunction

  xdmi_state_type q;
  xdmi_state_type d;
  logic [7:0]     idx_w;
  logic [15:0]    eff_w;
  logic           own_w;
  logic           flash_path_w;
  logic           ram_en_w;
  logic [7:0]     ram_rdata_w;
  xdmi_port_type  own_mask_w;
  xdmi_port_type  val_w;
  xdmi_port_type  drv_w;

  // ==========================================================================
  // Effective address of a new request
  assign idx_w        = MOVX_REQ_IN.idx_sel ? MOVX_REQ_IN.idx1 : MOVX_REQ_IN.idx0; // R04
  assign eff_w        = MOVX_REQ_IN.form16 ? {q.ptr_hi, q.ptr_lo} : {q.page, idx_w}; // R01 R02 R19
  assign flash_path_w = MOVX_REQ_IN.wr & q.flash_en; // R05
  assign own_w        = (q.st == ST_ALE) || (q.st == ST_ADDR) || (q.st == ST_STRB) || (q.st == ST_HOLD); // R07

  // ==========================================================================
  // Next-state logic
  always_comb begin
    d           = q;
    d.done      = 1'b0;
    d.flash_wr  = 1'b0;
    d.reg_rdata = 8'h00;
    // Three-stage pin synchroniser; a change counts once the last two agree.
    d.sync1 = PIN_IN.p6;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    if (q.sync2 == q.sync3) begin
      d.filt = q.sync3;
    end

    if (REG_WR_IN) begin
      if (REG_ADDR_IN == REG_PAGE) begin
        d.page = REG_WDATA_IN; // R19
      end else if (REG_ADDR_IN == REG_CFG) begin
        d.nonmux   = REG_WDATA_IN[CFG_MUX]; // R20
        d.mem_mode = REG_WDATA_IN[CFG_MODE_L+:2]; // R17
      end else if (REG_ADDR_IN == REG_PTRH) begin
        d.ptr_hi = REG_WDATA_IN; // R03
      end else if (REG_ADDR_IN == REG_PTRL) begin
        d.ptr_lo = REG_WDATA_IN; // R03
      end else if (REG_ADDR_IN == REG_STAT) begin
        if (REG_WDATA_IN[STAT_CONF]) begin
          d.conflict = 1'b0;
        end
      end else if (REG_ADDR_IN == REG_CTRL) begin
        d.flash_en = REG_WDATA_IN[CTRL_FLASH]; // R05
      end
    end

    if (REG_RD_IN) begin
      if (REG_ADDR_IN == REG_PAGE) begin
        d.reg_rdata = q.page;
      end else if (REG_ADDR_IN == REG_CFG) begin
        d.reg_rdata = {3'h0, q.nonmux, q.mem_mode, 2'h0};
      end else if (REG_ADDR_IN == REG_PTRH) begin
        d.reg_rdata = q.ptr_hi; // R03
      end else if (REG_ADDR_IN == REG_PTRL) begin
        d.reg_rdata = q.ptr_lo; // R03
      end else if (REG_ADDR_IN == REG_STAT) begin
        d.reg_rdata = {4'h0, q.last_off, q.conflict, own_w, q.st != ST_IDLE};
      end else if (REG_ADDR_IN == REG_CTRL) begin
        d.reg_rdata = {7'h00, q.flash_en};
      end
    end

    case (q.st)
      ST_IDLE: begin
        if (MOVX_REQ_IN.valid) begin
          d.addr    = eff_w;
          d.wdata   = MOVX_REQ_IN.wdata;
          d.is_wr   = MOVX_REQ_IN.wr;
          // The 8-bit form in plain split mode leaves the upper pins to the latches.
          d.hi_pins = MOVX_REQ_IN.form16 || (q.mem_mode == MM_SPLIT_BANK) || (q.mem_mode == MM_OFFCHIP); // R14
          if (flash_path_w) begin
            d.flash_wr = 1'b1; // R05
            d.done     = 1'b1;
          end else if (!goes_offchip(eff_w, q.mem_mode)) begin
            d.st = ST_RAM; // R06
          end else if (LCD_ACTIVE_IN) begin
            // Refused: the display owns the shared pins, so nothing is driven.
            d.conflict = 1'b1; // R11
            d.done     = 1'b1;
          end else begin
            d.last_off = 1'b1;
            if (q.nonmux) begin
              d.st  = ST_ADDR; // R13
              d.cnt = ADDR_CYC;
            end else begin
              d.st  = ST_ALE; // R21
              d.cnt = ALE_CYC;
            end
          end
          if (goes_offchip(eff_w, q.mem_mode) == 1'b0) begin
            d.last_off = 1'b0;
          end
        end
      end
      ST_RAM: begin
        d.st = ST_RAMD;
      end
      ST_RAMD: begin
        if (!q.is_wr) begin
          d.rdata = ram_rdata_w;
        end
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
      ST_ALE: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.st  = ST_ADDR;
          d.cnt = ADDR_CYC;
        end
      end
      ST_ADDR: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.st  = ST_STRB;
          d.cnt = STRB_CYC;
        end
      end
      ST_STRB: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          if (!q.is_wr) begin
            d.rdata = q.filt;
          end
          d.st  = ST_HOLD;
          d.cnt = HOLD_CYC;
        end
      end
      ST_HOLD: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.st   = ST_IDLE; // R08
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // On-chip RAM
  assign ram_en_w = (q.st == ST_RAM);

  xdmi_ram #(
    .AW (RAM_AW)
  ) u_ram (
    .clk_in    (REF_CLK_IN),
    .en_in     (ram_en_w),
    .we_in     (q.is_wr),
    .addr_in   (q.addr[RAM_AW-1:0]),
    .wdata_in  (q.wdata),
    .rdata_out (ram_rdata_w)
  );

  // ==========================================================================
  // Pin drive
  always_comb begin
    own_mask_w = '0;
    val_w      = '0;
    drv_w      = '0;
    if (own_w) begin
      own_mask_w.p3 = q.nonmux ? 8'hc0 : 8'he0; // R07 R12
      val_w.p3      = {~((q.st == ST_STRB) & q.is_wr), ~((q.st == ST_STRB) & ~q.is_wr),
                       q.st == ST_ALE, 5'h00}; // R21 R22
      drv_w.p3      = 8'he0;
      own_mask_w.p6 = 8'hff;
      if (q.nonmux) begin
        val_w.p6      = q.wdata; // R13
        drv_w.p6      = {8{q.is_wr}}; // R09
        own_mask_w.p5 = 8'hff;
        val_w.p5      = q.addr[7:0];
        drv_w.p5      = 8'hff;
        own_mask_w.p4 = {8{q.hi_pins}}; // R14
        val_w.p4      = q.addr[15:8];
        drv_w.p4      = 8'hff;
      end else begin
        val_w.p6      = ((q.st == ST_ALE) || (q.st == ST_ADDR)) ? q.addr[7:0] : q.wdata; // R12 R21
        drv_w.p6      = {8{(q.st == ST_ALE) || (q.st == ST_ADDR) || q.is_wr}}; // R09
        own_mask_w.p5 = {8{q.hi_pins}}; // R14
        val_w.p5      = q.addr[15:8];
        drv_w.p5      = 8'hff;
      end
    end
  end

  xdmi_pins u_pins (
    .own_in   (own_mask_w),
    .val_in   (val_w),
    .drv_in   (drv_w),
    .latch_in (LATCH_IN),
    .od_in    (OPEN_DRAIN_IN),
    .pin_out  (PIN_OUT),
    .oe_n_out (PIN_OE_N_OUT)
  );

  // ==========================================================================
  // Outputs
  assign REG_RDATA_OUT  = q.reg_rdata;
  assign EXT_ACTIVE_OUT = own_w; // R11
  assign MOVX_RSP_OUT   = '{done: q.done, busy: q.st != ST_IDLE, rdata: q.rdata};
  assign FLASH_OUT      = '{wr: q.flash_wr, addr: q.addr, data: q.wdata};

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  localparam int ALE_DLY = int'(ALE_CYC);
  logic accept_w;
  assign accept_w = (q.st == ST_IDLE) && MOVX_REQ_IN.valid;

  property p_page_high;
    accept_w && !MOVX_REQ_IN.form16 && !flash_path_w |=> q.addr[15:8] == $past(q.page);
  endproperty
  a_page_high: assert property (p_page_high) else $error("page byte not used as high address"); // R01

  property p_ptr_addr;
    accept_w && MOVX_REQ_IN.form16 |=> q.addr == {$past(q.ptr_hi), $past(q.ptr_lo)};
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer not used as address"); // R02

  property p_ptr_read;
    REG_RD_IN && (REG_ADDR_IN == REG_PTRL) |=> REG_RDATA_OUT == $past(q.ptr_lo);
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer low byte read wrong"); // R03

  property p_idx_low;
    accept_w && !MOVX_REQ_IN.form16 |=> q.addr[7:0] == $past(idx_w);
  endproperty
  a_idx_low: assert property (p_idx_low) else $error("index byte not used as low address"); // R04

  property p_flash;
    accept_w && flash_path_w |=> FLASH_OUT.wr && MOVX_RSP_OUT.done && !own_w;
  endproperty
  a_flash: assert property (p_flash) else $error("flash write not redirected"); // R05

  property p_ram;
    accept_w && !flash_path_w && !goes_offchip(eff_w, q.mem_mode) |-> ##3 MOVX_RSP_OUT.done ##0 !own_w;
  endproperty
  a_ram: assert property (p_ram) else $error("on-chip access not done in three cycles"); // R06

  property p_claim;
    $rose(own_w) |-> $past(accept_w) && !$past(LCD_ACTIVE_IN);
  endproperty
  a_claim: assert property (p_claim) else $error("pins claimed without an off-chip access"); // R07 R11

  property p_release;
    $fell(own_w) |-> MOVX_RSP_OUT.done && (PIN_OUT == LATCH_IN);
  endproperty
  a_release: assert property (p_release) else $error("pins not returned to latches"); // R08

  property p_read_hiz;
    own_w && !q.is_wr && (q.st == ST_STRB) |-> PIN_OE_N_OUT.p6 == 8'hff;
  endproperty
  a_read_hiz: assert property (p_read_hiz) else $error("data pins driven during read"); // R09

  property p_mux_addr;
    $rose(q.st == ST_ALE) |-> PIN_OUT.p3[5] && (PIN_OUT.p6 == q.addr[7:0]) ##ALE_DLY (q.st == ST_ADDR);
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("latch enable phase wrong"); // R12 R21

  property p_nonmux_addr;
    own_w && q.nonmux |-> PIN_OUT.p5 == q.addr[7:0];
  endproperty
  a_nonmux_addr: assert property (p_nonmux_addr) else $error("low address missing on port 5"); // R13

  property p_no_upper;
    own_w && !q.hi_pins && !q.nonmux |-> PIN_OUT.p5 == LATCH_IN.p5;
  endproperty
  a_no_upper: assert property (p_no_upper) else $error("upper address pins claimed"); // R14

  property p_strobe;
    $rose(q.st == ST_STRB) |-> (!PIN_OUT.p3[{2'b11, q.is_wr}] && PIN_OUT.p3[{2'b11, ~q.is_wr}])[*8];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe wrong or not eight cycles"); // R22

  c_mux_read:    cover property ($rose(q.st == ST_ALE) && !q.is_wr);
  c_nonmux_wr:   cover property ($rose(q.st == ST_STRB) && q.nonmux && q.is_wr);
  c_lcd_refused: cover property ($rose(q.conflict));
  c_ram_read:    cover property ((q.st == ST_RAMD) && !q.is_wr);
endmodule
`default_nettype wire

// ### xdmi_sram_model.sv
// Off-chip parallel memory as seen through the four port pin groups.
`timescale 1ns/1ps
`default_nettype none
module xdmi_sram_model (
  input  wire logic                    clk_in,
  input  wire logic                    nonmux_in,
  input  wire logic [1:0]              slow_in,
  input  wire xdmi_pkg::xdmi_port_type pin_in,
  input  wire xdmi_pkg::xdmi_port_type oe_n_in,
  output xdmi_pkg::xdmi_port_type      lvl_out
);
  import xdmi_pkg::*;
  logic [7:0]  mem [65536];
  logic [7:0]  alat = '0;
  logic [7:0]  noise = 8'h5a;
  logic [1:0]  rcnt = '0;
  logic        wr_q = 1'b1;
  logic [15:0] addr;
  logic [7:0]  l3;
  logic [7:0]  l4;
  logic [7:0]  l5;
  logic [7:0]  l6;
  // ==========================================================================
  // Wire levels
  // Ports 3 to 5 carry pull-ups; the data port floats, so a released data port shows a changing pattern.
  assign l3 = (~oe_n_in.p3 & pin_in.p3) | oe_n_in.p3;
  assign l4 = (~oe_n_in.p4 & pin_in.p4) | oe_n_in.p4;
  assign l5 = (~oe_n_in.p5 & pin_in.p5) | oe_n_in.p5;
  assign addr = nonmux_in ? {l4, l5} : {l5, alat};
  // A slow part shows garbage for the first slow_in cycles of the read strobe.
  assign l6 = (~oe_n_in.p6 & pin_in.p6) | (oe_n_in.p6 & ((!l3[6] && rcnt >= slow_in) ? mem[addr] : noise));
  assign lvl_out = {l6, l5, l4, l3};
  // ==========================================================================
  // Latch, strobes and storage
  always @(posedge clk_in) begin
    noise <= noise + 8'h3b;
    rcnt <= l3[6] ? 2'h0 : (rcnt == 2'h3 ? 2'h3 : rcnt + 2'h1);
    wr_q <= l3[7];
    if (l3[5] && !nonmux_in)
      alat <= l6;
    if (l3[7] && !wr_q)
      mem[addr] <= l6;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the external data memory interface with an off-chip memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import xdmi_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [2:0]     ra = '0;
  logic [7:0]     rwd = '0;
  logic           rwr = 1'b0;
  logic           rrd = 1'b0;
  logic [7:0]     rrdata;
  xdmi_req_type   req = '0;
  xdmi_rsp_type   rsp;
  xdmi_flash_type fl;
  logic           lcd = 1'b0;
  logic           ext;
  xdmi_port_type  pin_lvl;
  xdmi_port_type  pout;
  xdmi_port_type  poe_n;
  xdmi_port_type  latch = '1;
  xdmi_port_type  od = '0;
  logic           nonmux = 1'b0;
  logic [1:0]     slow = '0;
  int             miscompares = 0;
  int             check_count = 0;
  logic [7:0]     onchip_external_ram [8192];
  int unsigned    n_act, n_ale, n_rd, n_wr, n_bad;
  logic [7:0]     got;
  logic [7:0]     fd;
  logic [15:0]    fa;
  logic           fw;

  always #2.5 clk = ~clk;

  xdmi_top xdmi_top_inst (.REF_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(ra), .REG_WDATA_IN(rwd),
    .REG_WR_IN(rwr), .REG_RD_IN(rrd), .REG_RDATA_OUT(rrdata), .MOVX_REQ_IN(req), .MOVX_RSP_OUT(rsp),
    .FLASH_OUT(fl), .LCD_ACTIVE_IN(lcd), .EXT_ACTIVE_OUT(ext), .PIN_IN(pin_lvl), .LATCH_IN(latch),
    .OPEN_DRAIN_IN(od), .PIN_OUT(pout), .PIN_OE_N_OUT(poe_n));
  xdmi_sram_model xdmi_sram_model_inst (.clk_in(clk), .nonmux_in(nonmux), .slow_in(slow), .pin_in(pout),
    .oe_n_in(poe_n), .lvl_out(pin_lvl));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 d = rrdata;
  endtask

  // Runs one move-external access and gathers pin statistics until done.
  task automatic movx(input logic w, input logic f16, input logic sel, input logic [7:0] lo,
                      input logic [7:0] wd, input logic noup);
    int k;
    @(posedge clk);
    req <= '{valid: 1'b1, wr: w, form16: f16, idx_sel: sel, idx0: sel ? ~lo : lo, idx1: sel ? lo : ~lo,
             wdata: wd};
    @(posedge clk);
    req.valid <= 1'b0;
    {n_act, n_ale, n_rd, n_wr, n_bad, fw} = '0;
    for (k = 0; k < 40; k++) begin
      #1;
      if (fl.wr === 1'b1) begin
        fw = 1'b1;
        fa = fl.addr;
        fd = fl.data;
      end
      if (rsp.done === 1'b1)
        break;
      n_act += ext;
      if (ext && !poe_n.p3[5] && pout.p3[5] && poe_n.p6 === 8'h00 && n_rd + n_wr == 0)
        n_ale++;
      n_rd += ext && !pout.p3[6];
      n_wr += ext && !pout.p3[7];
      if (ext && !pout.p3[6] && poe_n.p6 !== 8'hff)
        n_bad++;
      if ((pout & od & ~poe_n) !== '0)
        n_bad++;
      if (ext && noup && (nonmux ? pout.p4 : pout.p5) !== (nonmux ? latch.p4 : latch.p5))
        n_bad++;
      @(posedge clk);
    end
    if (k == 40) begin
      miscompares++;
      final_report();
    end
    got = rsp.rdata;
    chk(ext, 1'b0);
    chk(pout, latch);
    chk(poe_n, od & latch);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    int m, i;
    logic [15:0] a;
    logic [7:0] d;
    logic off;
    void'($urandom(32'h8b78));
    od = {24'h0, 8'($urandom()) & 8'hdf};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      reg_rd(3'(i), got);
      chk(got, 0);
    end
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom()) & (i == 1 ? 8'h1c : 8'hff);
      reg_wr(3'(i), d);
      reg_rd(3'(i), got);
      chk(got, d);
    end
    reg_wr(3'h6, 8'hff);
    reg_rd(3'h6, got);
    chk(got, 0);
    // Every memory mode in both pin modes; split and off-chip-only modes see a slow far side, the others a prompt one.
    for (m = 0; m < 8; m++) begin
      nonmux = m[0];
      slow = m[1] ? 2'h3 : 2'h0;
      reg_wr(REG_CFG, {3'h0, m[0], 2'(m >> 1), 2'h0});
      a = 16'($urandom());
      if (m >> 1 == 1)
        a[15:8] = 8'hff;
      off = (m >> 1 == 3) || (m >> 1 != 0 && a >= 16'h2000);
      d = 8'($urandom());
      reg_wr(REG_PTRH, a[15:8]);
      reg_wr(REG_PTRL, a[7:0]);
      movx(1'b1, 1'b1, 1'b0, 8'h0, d, 1'b0);
      chk(n_wr, off ? STRB_CYC : 0);
      if (off)
        chk(xdmi_sram_model_inst.mem[a], d);
      else
        onchip_external_ram[a[12:0]] = d;
      // Plain split mode must ignore the page on the pins, so a wrong drive reads an empty address.
      reg_wr(REG_PAGE, (m >> 1 == 1) ? 8'hfe : a[15:8]);
      movx(1'b0, 1'b0, m[1], a[7:0], 8'h0, off && m >> 1 == 1);
      chk(got, off ? d : onchip_external_ram[a[12:0]]);
      chk(n_rd, off ? STRB_CYC : 0);
      chk(n_ale, off && !m[0] ? ALE_CYC : 0);
      chk(n_bad, 0);
    end
    reg_wr(REG_CFG, 8'h00);
    movx(1'b1, 1'b1, 1'b0, 8'h0, 8'hc3, 1'b0);
    reg_wr(REG_CTRL, 8'h01);
    movx(1'b1, 1'b1, 1'b0, 8'h0, 8'h3c, 1'b0);
    chk({fw, fa, fd}, {1'b1, a, 8'h3c});
    movx(1'b0, 1'b1, 1'b0, 8'h0, 8'h0, 1'b0);
    chk(got, 8'hc3);
    reg_wr(REG_CTRL, 8'h00);
    reg_wr(REG_CFG, 8'h0c);
    lcd <= 1'b1;
    movx(1'b0, 1'b1, 1'b0, 8'h0, 8'h0, 1'b0);
    chk(n_act, 0);
    reg_rd(REG_STAT, got);
    chk(got[STAT_CONF], 1'b1);
    @(posedge clk);
    lcd <= 1'b0;
    reg_wr(REG_STAT, 8'h04);
    reg_rd(REG_STAT, got);
    chk(got[STAT_CONF], 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
